// >>> exec_core.sv
// execution of bit-test-skip, clear, call and watchdog-clear instructions
// assumes one instruction per I_SYS_CLK cycle, file read data valid combinationally
// Function
// - skip-when-one: bit set discards next instruction, runs nop, two cycles
// - skip-when-one: bit clear runs next normally; no flag changes
// - skip-when-zero: bit clear discards next, two cycles; bit set continues
// - clear-file writes 00h to file register and sets zero flag only
// - clear-accumulator loads 00h into working register, sets zero flag
// - call pushes pc plus one onto return stack head; no flags
// - call loads 11-bit immediate into pc bits 10..0
// - call fills pc bits 12..11 from latch bits 4..3
// - call takes two cycles; fetched instruction is flushed
// - watchdog clear zeroes watchdog counter and its prescaler
// - watchdog clear sets both active-low expiry and sleep flags
module exec_core (
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST_N,
  input  wire logic [13:0] I_INSTR,
  input  wire logic [7:0]  I_FILE_RDATA,
  input  wire logic [7:0]  I_PC_HIGH_LATCH,
  input  wire logic        I_WDOG_TICK,
  output logic [12:0]      O_PC,
  output logic [6:0]       O_FILE_ADDR,
  output logic [7:0]       O_FILE_WDATA,
  output logic             O_FILE_WE,
  output logic [7:0]       O_ACC,
  output logic [7:0]       O_STATUS,
  output logic             O_PUSH,
  output logic [12:0]      O_RETURN_STACK_HEAD,
  output logic [7:0]       O_WATCHDOG_COUNTER,
  output logic [7:0]       O_WDOG_PRESCALER,
  output logic             O_FLUSH
);
  // ****************************************
  // decode
  // ****************************************
  logic        skip_one;
  logic        skip_zero;
  logic        clr_file;
  logic        clr_acc;
  logic        wdog_clr;
  logic        call_op;
  logic [6:0]  file_addr;
  logic [2:0]  bit_sel;
  logic [10:0] imm;

  exec_decode u_dec (
    .i_instr     (I_INSTR),
    .o_skip_one  (skip_one),
    .o_skip_zero (skip_zero),
    .o_clr_file  (clr_file),
    .o_clr_acc   (clr_acc),
    .o_wdog_clr  (wdog_clr),
    .o_call      (call_op),
    .o_file_addr (file_addr),
    .o_bit_sel   (bit_sel),
    .o_imm       (imm)
  );

  exec_pkg::exec_state_t state_q, state_d;
  logic [12:0] pc_q, pc_d;
  logic [7:0]  acc_q, acc_d;
  logic [7:0]  status_q, status_d;
  logic [12:0] head_q;
  logic [7:0]  wdog_q, pre_q;
  logic [7:0]  wdata_q;
  logic        push_q;

  // an instruction in the flush slot executes as a nop
  wire         active    = state_q == exec_pkg::ST_RUN;
  wire         sel_bit   = I_FILE_RDATA[bit_sel];
  wire         skip_take = active & ((skip_one & sel_bit) | (skip_zero & ~sel_bit));
  wire         do_call   = active & call_op;
  wire         do_clear_file_register_op   = active & clr_file;
  wire         do_clear_accumulator_op   = active & clr_acc;
  wire         do_wclr   = active & wdog_clr;
  wire [12:0]  pc_inc    = pc_q + 13'h0001;
  wire [12:0]  call_tgt  = {I_PC_HIGH_LATCH[exec_pkg::LATCH_LSB +: 2], imm};

  // ****************************************
  // next state
  // ****************************************
  // skip and call both spend a second cycle on a discarded fetch
  assign state_d = (skip_take | do_call) ? exec_pkg::ST_FLUSH : exec_pkg::ST_RUN;
  assign pc_d    = do_call ? call_tgt : pc_inc;
  assign acc_d   = do_clear_accumulator_op ? exec_pkg::ZERO_BYTE : acc_q;

  always_comb begin
    status_d = status_q;
    if (do_clear_file_register_op || do_clear_accumulator_op) begin
      status_d[exec_pkg::STAT_Z] = 1'b1;
    end
    if (do_wclr) begin
      status_d[exec_pkg::STAT_TO_N] = 1'b1;
      status_d[exec_pkg::STAT_PD_N] = 1'b1;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_q  <= exec_pkg::ST_RUN;
      pc_q     <= exec_pkg::PC_RST;
      acc_q    <= exec_pkg::ZERO_BYTE;
      status_q <= exec_pkg::STATUS_RST;
    end else begin
      state_q  <= state_d;
      pc_q     <= pc_d;
      acc_q    <= acc_d;
      status_q <= status_d;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      head_q  <= exec_pkg::PC_RST;
      push_q  <= 1'b0;
      wdata_q <= exec_pkg::ZERO_BYTE;
    end else begin
      push_q  <= do_call;
      if (do_call) begin
        head_q <= pc_inc;
      end
      wdata_q <= exec_pkg::ZERO_BYTE;
    end
  end

  // watchdog: prescaler counts ticks, counter advances when prescaler wraps
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      wdog_q <= exec_pkg::WDOG_RST;
      pre_q  <= exec_pkg::WDOG_RST;
    end else if (do_wclr) begin
      wdog_q <= exec_pkg::WDOG_RST;
      pre_q  <= exec_pkg::WDOG_RST;
    end else if (I_WDOG_TICK) begin
      pre_q  <= pre_q + 8'h01;
      if (pre_q == 8'hff) begin
        wdog_q <= wdog_q + 8'h01;
      end
    end
  end

  // clear writes in its own cycle: a late write would steer the address
  // away from the operand that a following skip must read
  assign O_PC                = pc_q;
  assign O_FILE_ADDR         = file_addr;
  assign O_FILE_WDATA        = wdata_q;
  assign O_FILE_WE           = do_clear_file_register_op;
  assign O_ACC               = acc_q;
  assign O_STATUS            = status_q;
  assign O_PUSH              = push_q;
  assign O_RETURN_STACK_HEAD = head_q;
  assign O_WATCHDOG_COUNTER  = wdog_q;
  assign O_WDOG_PRESCALER    = pre_q;
  assign O_FLUSH             = state_q == exec_pkg::ST_FLUSH;

  // ****************************************
  // checks
  // ****************************************
  property p_skip_one;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (active && skip_one && sel_bit) |=> O_FLUSH ##1 !O_FLUSH;
  endproperty
  a_skip_one: assert property (p_skip_one) else $error("skip on one missing");

  property p_skip_one_no;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (active && skip_one && !sel_bit) |=> !O_FLUSH && $stable(O_STATUS);
  endproperty
  a_skip_one_no: assert property (p_skip_one_no) else $error("bad skip on zero bit");

  property p_skip_zero;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (active && skip_zero) |=> (O_FLUSH == !$past(sel_bit)) && $stable(O_STATUS);
  endproperty
  a_skip_zero: assert property (p_skip_zero) else $error("skip on zero wrong");

  property p_clear_file_register_op;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (active && clr_file) |-> (O_FILE_WE && O_FILE_WDATA == 8'h00
      && O_FILE_ADDR == I_INSTR[6:0]) ##1 O_STATUS[exec_pkg::STAT_Z];
  endproperty
  a_clear_file_register_op: assert property (p_clear_file_register_op) else $error("clear file failed");

  property p_no_write_flush;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    O_FLUSH |-> !O_FILE_WE;
  endproperty
  a_no_write_flush: assert property (p_no_write_flush) else $error("write in flush slot");

  property p_clear_accumulator_op;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (active && clr_acc) |=> O_ACC == 8'h00 && O_STATUS[exec_pkg::STAT_Z]
      && O_STATUS[7:3] == $past(O_STATUS[7:3]) && O_STATUS[1:0] == $past(O_STATUS[1:0]);
  endproperty
  a_clear_accumulator_op: assert property (p_clear_accumulator_op) else $error("clear acc failed");

  property p_call_push;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (active && call_op) |=> O_PUSH && O_RETURN_STACK_HEAD == $past(O_PC) + 13'h0001
      && $stable(O_STATUS);
  endproperty
  a_call_push: assert property (p_call_push) else $error("call push wrong");

  property p_call_pc;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (active && call_op) |=> O_PC[10:0] == $past(imm)
      && O_PC[12:11] == $past(I_PC_HIGH_LATCH[4:3]);
  endproperty
  a_call_pc: assert property (p_call_pc) else $error("call target wrong");

  property p_call_flush;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (active && call_op) |=> O_FLUSH ##1 (!O_FLUSH && !O_PUSH);
  endproperty
  a_call_flush: assert property (p_call_flush) else $error("call not two cycles");

  property p_wclr;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (active && wdog_clr) |=> O_WATCHDOG_COUNTER == 8'h00 && O_WDOG_PRESCALER == 8'h00
      && O_STATUS[4:3] == 2'b11 && O_STATUS[2:0] == $past(O_STATUS[2:0])
      && O_STATUS[7:5] == $past(O_STATUS[7:5]);
  endproperty
  a_wclr: assert property (p_wclr) else $error("watchdog clear failed");
endmodule

// >>> exec_decode.sv
// instruction field decoder for the execution block
// assumes a 14-bit instruction word, purely combinational
module exec_decode (
  input  wire logic [13:0] i_instr,
  output logic             o_skip_one,
  output logic             o_skip_zero,
  output logic             o_clr_file,
  output logic             o_clr_acc,
  output logic             o_wdog_clr,
  output logic             o_call,
  output logic [6:0]       o_file_addr,
  output logic [2:0]       o_bit_sel,
  output logic [10:0]      o_imm
);
  assign o_skip_one  = i_instr[13:10] == exec_pkg::OP_SKIP_ONE_HI;
  assign o_skip_zero = i_instr[13:10] == exec_pkg::OP_SKIP_ZERO_HI;
  assign o_clr_file  = i_instr[13:7] == exec_pkg::OP_CLEAR_FILE_REGISTER_OP_HI;
  assign o_clr_acc   = i_instr == exec_pkg::OP_CLEAR_ACCUMULATOR_OP;
  assign o_wdog_clr  = i_instr == exec_pkg::OP_WDOG_CLR;
  assign o_call      = i_instr[13:11] == exec_pkg::OP_CALL_HI;
  assign o_file_addr = i_instr[exec_pkg::FILE_LSB +: exec_pkg::FILE_W];
  assign o_bit_sel   = i_instr[exec_pkg::BIT_LSB +: exec_pkg::BIT_W];
  assign o_imm       = i_instr[exec_pkg::IMM_W-1:0];
endmodule

// >>> exec_pkg.sv
// shared constants for the bit-test, clear, call and watchdog-clear execution block
// assumes 14-bit instruction words and an 8-bit data path
package exec_pkg;
  // ****************************************
  // instruction encodings
  // ****************************************
  localparam logic [3:0]  OP_SKIP_ONE_HI  = 4'h7;   // 01 11bb bfff ffff
  localparam logic [3:0]  OP_SKIP_ZERO_HI = 4'h6;   // 01 10bb bfff ffff
  localparam logic [6:0]  OP_CLEAR_FILE_REGISTER_OP_HI      = 7'h03;  // 00 0001 1fff ffff
  localparam logic [13:0] OP_CLEAR_ACCUMULATOR_OP         = 14'h0100;
  localparam logic [13:0] OP_WDOG_CLR     = 14'h0064;
  localparam logic [2:0]  OP_CALL_HI      = 3'h4;   // 10 0kkk kkkk kkkk
  localparam logic [13:0] OP_NOP          = 14'h0000;
  // ****************************************
  // field positions
  // ****************************************
  localparam int FILE_LSB  = 0;
  localparam int FILE_W    = 7;
  localparam int BIT_LSB   = 7;
  localparam int BIT_W     = 3;
  localparam int IMM_W     = 11;
  localparam int LATCH_LSB = 3;
  // ****************************************
  // status bit positions and reset values
  // ****************************************
  localparam int STAT_Z    = 2;
  localparam int STAT_PD_N = 3;
  localparam int STAT_TO_N = 4;
  localparam logic [7:0]  STATUS_RST  = 8'h18;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;
  localparam logic [12:0] PC_RST      = 13'h0000;
  localparam logic [7:0]  WDOG_RST    = 8'h00;
  typedef enum logic [1:0] {ST_RUN = 2'b00, ST_FLUSH = 2'b01} exec_state_t;
endpackage

// >>> tb.sv
// self-checking bench for exec_core: directed corners, then a seeded random stream
// assumes exec_pkg is compiled first; the bench plays the file memory and the latch
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, tick, e_fl, e_push;
  logic [13:0] instr;
  logic [7:0]  rdata, latch, e_acc, e_st, e_wd, e_ps;
  logic [12:0] e_pc, e_head;
  wire  [12:0] o_pc, o_head;
  wire  [7:0]  o_wdata, o_acc, o_st, o_wd, o_ps;
  wire  [6:0]  o_addr;
  wire         o_we, o_push, o_fl;
  int          seed = 45622;
  int          n_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  exec_core i_exec_core (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_INSTR(instr),
    .I_FILE_RDATA(rdata), .I_PC_HIGH_LATCH(latch), .I_WDOG_TICK(tick), .O_PC(o_pc),
    .O_FILE_ADDR(o_addr), .O_FILE_WDATA(o_wdata), .O_FILE_WE(o_we), .O_ACC(o_acc),
    .O_STATUS(o_st), .O_PUSH(o_push), .O_RETURN_STACK_HEAD(o_head),
    .O_WATCHDOG_COUNTER(o_wd), .O_WDOG_PRESCALER(o_ps), .O_FLUSH(o_fl));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ****************************************
  // reference model
  // ****************************************
  function automatic logic skip_exp(input logic [13:0] x, input logic [7:0] d);
    if (x[13:10] == exec_pkg::OP_SKIP_ONE_HI) return d[x[9:7]];
    if (x[13:10] == exec_pkg::OP_SKIP_ZERO_HI) return !d[x[9:7]];
    return 1'b0;
  endfunction
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {e_pc, e_head, e_fl, e_push, e_acc, e_wd, e_ps} <= '0;
      e_st <= exec_pkg::STATUS_RST;
    end else begin
      e_pc <= e_pc + 13'h1;
      {e_fl, e_push} <= 2'h0;
      if (tick) begin
        e_ps <= e_ps + 8'h01;
        if (e_ps == 8'hff) e_wd <= e_wd + 8'h01;
      end
      // a discarded instruction must leave every register alone
      if (!e_fl) begin
        e_fl <= skip_exp(instr, rdata);
        if (instr[13:7] == exec_pkg::OP_CLEAR_FILE_REGISTER_OP_HI) begin
          e_st[2] <= 1'b1;
        end else if (instr == exec_pkg::OP_CLEAR_ACCUMULATOR_OP) begin
          e_acc <= 8'h00;
          e_st[2] <= 1'b1;
        end else if (instr == exec_pkg::OP_WDOG_CLR) begin
          {e_wd, e_ps} <= 16'h0000;
          e_st[4:3] <= 2'h3;
        end else if (instr[13:11] == exec_pkg::OP_CALL_HI) begin
          e_pc <= {latch[4:3], instr[10:0]};
          e_head <= e_pc + 13'h1;
          e_push <= 1'b1;
          e_fl <= 1'b1;
        end
      end
    end
  end
  // ****************************************
  // checking
  // ****************************************
  task automatic chk(input string what, input logic [12:0] seen, input logic [12:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(negedge clk) begin
    if (rst_n) begin
      chk("flush", 13'(o_fl), 13'(e_fl));
      chk("pc", o_pc, e_pc);
      chk("push", 13'(o_push), 13'(e_push));
      chk("head", o_head, e_head);
      chk("we", 13'(o_we), 13'(!e_fl && instr[13:7] == exec_pkg::OP_CLEAR_FILE_REGISTER_OP_HI));
      chk("wdata", 13'(o_wdata), 13'h0);
      chk("addr", 13'(o_addr), 13'(instr[6:0]));
      chk("acc", 13'(o_acc), 13'(e_acc));
      chk("status", 13'(o_st), 13'(e_st));
      chk("wdog", 13'(o_wd), 13'(e_wd));
      chk("presc", 13'(o_ps), 13'(e_ps));
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 9000) begin
      n_errors++;
      end_of_test();
    end
  end
  // ****************************************
  // stimulus
  // ****************************************
  task automatic put(input logic [13:0] x, input logic [7:0] r);
    @(posedge clk);
    instr <= x;
    rdata <= r;
    latch <= 8'($random(seed));
    // a tick beside a watchdog clear is dropped because the clear wins, so keep them apart
    tick <= (x != exec_pkg::OP_WDOG_CLR) && $random(seed) % 2;
  endtask
  function automatic logic [13:0] gen(input logic wd);
    case (4'($random(seed)))
      4'h0, 4'h1, 4'h2: return {exec_pkg::OP_SKIP_ONE_HI, 10'($random(seed))};
      4'h3, 4'h4, 4'h5: return {exec_pkg::OP_SKIP_ZERO_HI, 10'($random(seed))};
      4'h6, 4'h7: return {exec_pkg::OP_CLEAR_FILE_REGISTER_OP_HI, 7'($random(seed))};
      4'h8: return exec_pkg::OP_CLEAR_ACCUMULATOR_OP;
      4'h9, 4'ha: return {exec_pkg::OP_CALL_HI, 11'($random(seed))};
      4'hb: return wd ? exec_pkg::OP_WDOG_CLR : exec_pkg::OP_NOP;
      default: return {2'h3, 12'($random(seed))};
    endcase
  endfunction
  initial begin
    {rst_n, tick} = 2'h0;
    {instr, rdata, latch} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    put({4'h7, 3'h7, 7'h11}, 8'h80);   // bit 7 set: skip
    put({7'h03, 7'h05}, 8'h00);        // discarded clear
    put({4'h7, 3'h0, 7'h7f}, 8'hfe);
    put({4'h6, 3'h0, 7'h00}, 8'hfe);   // bit 0 clear: skip
    put({4'h6, 3'h7, 7'h22}, 8'h80);
    put({3'h4, 11'h7ff}, 8'h00);
    put({3'h4, 11'h000}, 8'h00);       // lands in the flushed slot
    put({7'h03, 7'h7f}, 8'h00);
    put(exec_pkg::OP_CLEAR_ACCUMULATOR_OP, 8'h00);
    put(exec_pkg::OP_WDOG_CLR, 8'h00);
    $display("directed corners done");
    repeat (1500) put(gen(1'b0), 8'($random(seed)));
    repeat (800) put(exec_pkg::OP_WDOG_CLR, 8'h00);
    repeat (1500) put(gen(1'b1), 8'($random(seed)));
    $display("random stream done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (200) put(gen(1'b1), 8'($random(seed)));
    $display("second reset done");
    end_of_test();
  end
endmodule
